// ===== core/rom_addr_map.vh
`ifndef ROM_ADDR_MAP_VH
`define ROM_ADDR_MAP_VH
`define REG_PROG_SEG 12'hFEC
`define REG_SPEECH_SEG 12'hFED
`define REG_OVERLAY 12'hFEE
`define RST_PROG_SEG 8'h00
`define RST_SPEECH_SEG 8'h00
`define RST_OVERLAY 8'h00
`define OVERLAY_BIT 0
`define VEC_INIT 16'h0000
`define VEC_WAKE 16'h0002
`define VEC_IRQ 16'h0010
`define OFFSET_SPLIT 16'h8000
`define OFFSET_MASK 16'h7FFF
`define PROG_SEG_SHIFT 12
`define SPEECH_SEG_SHIFT 15
`define INT_TOP 23'h000FFF
`define FETCH_DIV 16
`define STEAL_PHASE_1 2'h0
`define STEAL_PHASE_2 2'h2
`define OP_FETCH 3'h0
`define OP_JUMP 3'h1
`define OP_SETUP 3'h2
`define OP_GET 3'h3
`define OP_BYTE_ACC 3'h4
`define OP_BYTE_B 3'h5
`define OP_PITCH 3'h6
`define OP_EXC 3'h7
`define DEST_INSTR 2'h0
`define DEST_A 2'h1
`define DEST_B 2'h2
`define DEST_AUX 2'h3
`endif

// ===== core/rom_address_generation.v
`include "rom_addr_map.vh"
`default_nettype none
// Operation
// - offset below 8000h adds program segment base shifted left twelve.
// - offset 8000h or above masks to 15 bits, adds speech base shifted fifteen.
// - output ROM address is 23 bits wide.
// - 16-bit program counter increments by one after each instruction fetch.
// - overlay bit 0 set sends lowest 4K to external ROM, else internal.
// - above 000FFFh is external, except excitation code served internally.
// - init pin rising edge restarts execution at 0000h.
// - wake-up input falling edge restarts execution at 0002h.
// - interrupts vector into locations 0010h through 001Fh.
// - bit fetch moves 1 to 8 bits via read pointer; setup initialises.
// - byte lookup to A uses A value as address, loads byte into A.
// - byte lookup to B uses A value as address, loads byte into B.
// - without synthesis, instructions fetched at one sixteenth of clock.
// - each synthesizer steals a quarter of cycles; 3/4 or 1/2 rate.
// - space covers 4K internal plus up to 8M external ROM.
// - core offset comes from PC, pitch, read pointer, lookup or excitation.
// - interrupt loads program counter with its vector; execution resumes.
module rom_address_generation #(
    parameter FETCH_DIV = `FETCH_DIV
) (
    input wire mclk, // system clock
    input wire sys_rst, // synchronous reset, active high
    input wire init_pin, // initialization pin
    input wire io_wake, // i/o wake-up input
    input wire irq_req, // interrupt request pulse
    input wire [3:0] irq_line, // interrupt number with irq_req
    input wire [1:0] synth_en, // synthesizer enables
    input wire op_valid, // core operation present
    input wire [2:0] op_code, // core operation
    input wire [15:0] op_arg, // operation argument
    input wire [15:0] acc_value, // current A register value
    input wire reg_wr, // register write strobe
    input wire [11:0] reg_addr, // register address
    input wire [7:0] reg_wdata, // register write data
    output reg [7:0] reg_rdata, // register read data
    input wire [7:0] rom_ext_data, // byte from external ROM
    input wire [7:0] rom_int_data, // byte from internal ROM
    output reg [22:0] output_rom_address, // composed ROM address
    output reg rom_rd, // ROM access in progress
    output reg rom_ext_sel, // external ROM selected
    output reg rom_int_sel, // internal ROM selected
    output reg op_taken, // operation accepted pulse
    output reg result_valid, // result pulse
    output reg [1:0] result_dest, // result destination
    output reg [7:0] result_data, // result byte
    output reg [15:0] prog_count // program counter
);

    reg [7:0] program_segment_base;
    reg [7:0] speech_segment_base;
    reg [7:0] internal_rom_overlay_control;
    reg [15:0] speech_read_pointer;
    reg [3:0] slot;
    reg [1:0] phase;
    reg init_q;
    reg wake_q;
    reg wake_pend;
    reg irq_pend;
    reg [3:0] irq_num;
    reg active;
    reg [1:0] cur_dest;
    reg cur_get;
    reg [3:0] get_n;
    reg [15:0] bit_buf;
    reg [3:0] bit_avail;

    wire init_rise = init_pin & ~init_q;
    wire restart = sys_rst | init_rise;
    wire wake_fall = ~io_wake & wake_q;
    wire slot_first = (slot == 4'h0);
    wire slot_last = (slot == FETCH_DIV - 1);
    // a synthesizer owns one instruction cycle in every four
    wire stolen = (synth_en[0] && phase == `STEAL_PHASE_1) ||
        (synth_en[1] && phase == `STEAL_PHASE_2);
    wire grant = slot_first & ~stolen;

    function [22:0] compose;
        input [15:0] offs;
        input [7:0] pbase;
        input [7:0] sbase;
        begin
            if (offs < `OFFSET_SPLIT) begin
                compose = {7'h00, offs} + ({15'h0000, pbase} << `PROG_SEG_SHIFT);
            end else begin
                compose = {7'h00, offs & `OFFSET_MASK} +
                    ({15'h0000, sbase} << `SPEECH_SEG_SHIFT);
            end
        end
    endfunction

    function is_external;
        input [22:0] addr;
        input exc;
        input overlay;
        begin
            if (exc) begin
                is_external = 1'b0;
            end else if (addr <= `INT_TOP) begin
                is_external = overlay;
            end else begin
                is_external = 1'b1;
            end
        end
    endfunction

    reg [15:0] next_offset;
    reg next_access;
    reg next_exc;
    reg [1:0] next_dest;
    reg [3:0] next_n;
    reg [22:0] next_addr;
    always @* begin
        next_offset = prog_count;
        next_access = 1'b0;
        next_exc = 1'b0;
        next_dest = `DEST_INSTR;
        next_n = {1'b0, op_arg[2:0]} + 4'h1;
        case (op_code)
            `OP_FETCH: begin
                next_access = 1'b1;
            end
            `OP_GET: begin
                next_offset = speech_read_pointer;
                next_access = (bit_avail < next_n);
                next_dest = `DEST_A;
            end
            `OP_BYTE_ACC: begin
                next_offset = acc_value;
                next_access = 1'b1;
                next_dest = `DEST_A;
            end
            `OP_BYTE_B: begin
                next_offset = acc_value;
                next_access = 1'b1;
                next_dest = `DEST_B;
            end
            `OP_PITCH: begin
                next_offset = op_arg;
                next_access = 1'b1;
                next_dest = `DEST_AUX;
            end
            `OP_EXC: begin
                next_offset = op_arg;
                next_access = 1'b1;
                next_exc = 1'b1;
                next_dest = `DEST_AUX;
            end
            default: begin
                next_access = 1'b0;
            end
        endcase
        next_addr = compose(next_offset, program_segment_base, speech_segment_base);
    end

    // bit fetch: unread bits sit msb-first at the top of bit_buf
    wire [7:0] rd_byte = rom_ext_sel ? rom_ext_data : rom_int_data;
    wire [15:0] fill = rom_rd ? ({rd_byte, 8'h00} >> bit_avail) : 16'h0000;
    wire [15:0] merged = bit_buf | fill;
    wire [7:0] get_bits = merged[15:8] >> (4'h8 - get_n);
    wire [3:0] avail_fill = rom_rd ? (bit_avail + 4'h8) : bit_avail;

    always @(posedge mclk) begin
        if (sys_rst) begin
            init_q <= 1'b0;
            wake_q <= 1'b1;
        end else begin
            init_q <= init_pin;
            wake_q <= io_wake;
        end
    end

    always @(posedge mclk) begin
        if (restart) begin
            program_segment_base <= `RST_PROG_SEG;
            speech_segment_base <= `RST_SPEECH_SEG;
            internal_rom_overlay_control <= `RST_OVERLAY;
            reg_rdata <= 8'h00;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    `REG_PROG_SEG: program_segment_base <= reg_wdata;
                    `REG_SPEECH_SEG: speech_segment_base <= reg_wdata;
                    `REG_OVERLAY: internal_rom_overlay_control <= reg_wdata;
                    default: ;
                endcase
            end
            case (reg_addr)
                `REG_PROG_SEG: reg_rdata <= program_segment_base;
                `REG_SPEECH_SEG: reg_rdata <= speech_segment_base;
                `REG_OVERLAY: reg_rdata <= internal_rom_overlay_control;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always @(posedge mclk) begin
        if (restart) begin
            slot <= 4'h0;
            phase <= 2'h0;
        end else if (slot_last) begin
            slot <= 4'h0;
            phase <= phase + 2'h1;
        end else begin
            slot <= slot + 4'h1;
        end
    end

    always @(posedge mclk) begin
        if (restart) begin
            prog_count <= `VEC_INIT;
            speech_read_pointer <= 16'h0000;
            wake_pend <= 1'b0;
            irq_pend <= 1'b0;
            irq_num <= 4'h0;
            active <= 1'b0;
            cur_dest <= `DEST_INSTR;
            cur_get <= 1'b0;
            get_n <= 4'h1;
            bit_buf <= 16'h0000;
            bit_avail <= 4'h0;
            output_rom_address <= 23'h000000;
            rom_rd <= 1'b0;
            rom_ext_sel <= 1'b0;
            rom_int_sel <= 1'b0;
            op_taken <= 1'b0;
            result_valid <= 1'b0;
            result_dest <= `DEST_INSTR;
            result_data <= 8'h00;
        end else begin
            op_taken <= 1'b0;
            result_valid <= 1'b0;
            // events arriving while the pending flag is consumed are kept
            if (wake_fall) begin
                wake_pend <= 1'b1;
            end else if (grant) begin
                wake_pend <= 1'b0;
            end
            if (irq_req) begin
                irq_pend <= 1'b1;
                irq_num <= irq_line;
            end else if (grant && !wake_pend) begin
                irq_pend <= 1'b0;
            end
            if (grant) begin
                if (wake_pend) begin
                    prog_count <= `VEC_WAKE;
                end else if (irq_pend) begin
                    prog_count <= `VEC_IRQ | {12'h000, irq_num};
                end else if (op_valid) begin
                    op_taken <= 1'b1;
                    active <= (op_code != `OP_JUMP) && (op_code != `OP_SETUP);
                    cur_dest <= next_dest;
                    cur_get <= (op_code == `OP_GET);
                    get_n <= next_n;
                    rom_rd <= next_access;
                    output_rom_address <= next_addr;
                    rom_ext_sel <= next_access &
                        is_external(next_addr, next_exc,
                            internal_rom_overlay_control[`OVERLAY_BIT]);
                    rom_int_sel <= next_access &
                        ~is_external(next_addr, next_exc,
                            internal_rom_overlay_control[`OVERLAY_BIT]);
                    case (op_code)
                        `OP_FETCH: prog_count <= prog_count + 16'h0001;
                        `OP_JUMP: prog_count <= op_arg;
                        `OP_SETUP: begin
                            speech_read_pointer <= op_arg;
                            bit_buf <= 16'h0000;
                            bit_avail <= 4'h0;
                        end
                        `OP_GET: begin
                            if (next_access) begin
                                speech_read_pointer <= speech_read_pointer + 16'h0001;
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (slot_last && active) begin
                // the byte must be stable by the last slot of the cycle
                active <= 1'b0;
                rom_rd <= 1'b0;
                rom_ext_sel <= 1'b0;
                rom_int_sel <= 1'b0;
                result_valid <= 1'b1;
                result_dest <= cur_dest;
                if (cur_get) begin
                    result_data <= get_bits;
                    bit_buf <= merged << get_n;
                    bit_avail <= avail_fill - get_n;
                end else begin
                    result_data <= rd_byte;
                end
            end
        end
    end

endmodule // rom_address_generation
`default_nettype wire

// ===== test/rom_address_generation_asserts.sv
`include "rom_addr_map.vh"
`default_nettype none
module rom_address_generation_asserts (
    input wire logic mclk, // clock
    input wire logic sys_rst, // reset
    input wire logic init_pin, // init pin
    input wire logic io_wake, // wake input
    input wire logic irq_req, // irq pulse
    input wire logic [3:0] irq_line, // irq number
    input wire logic [2:0] op_code, // core op
    input wire logic reg_wr, // reg write
    input wire logic [11:0] reg_addr, // reg address
    input wire logic [7:0] reg_wdata, // reg data
    input wire logic [7:0] reg_rdata, // reg read data
    input wire logic [22:0] output_rom_address, // rom address
    input wire logic rom_rd, // rom access
    input wire logic rom_ext_sel, // external select
    input wire logic rom_int_sel, // internal select
    input wire logic op_taken, // op accepted
    input wire logic result_valid, // result pulse
    input wire logic [1:0] result_dest, // result target
    input wire logic [15:0] prog_count // program counter
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic [3:0] irq_num;
    // the vector depends on the line latched with the pulse, not the current one
    always_ff @(posedge mclk) if (irq_req) irq_num <= irq_line;
    sequence s_fetch; op_taken && $past(op_code) == `OP_FETCH; endsequence
    sequence s_ovl_wr;
        reg_wr && reg_addr == `REG_OVERLAY ##1 !reg_wr && $stable(reg_addr);
    endsequence
    property p_take_rd; s_fetch |-> rom_rd; endproperty
    property p_onehot; rom_rd |-> (rom_ext_sel ^ rom_int_sel); endproperty
    property p_high_ext; op_taken && rom_rd && $past(op_code) != `OP_EXC
        && output_rom_address > `INT_TOP |-> rom_ext_sel; endproperty
    property p_exc_int; op_taken && rom_rd && $past(op_code) == `OP_EXC |-> rom_int_sel; endproperty
    property p_fetch_res;
        s_fetch |-> ##15 (result_valid && result_dest == `DEST_INSTR);
    endproperty
    property p_fetch_pc; s_fetch |-> prog_count == $past(prog_count) + 16'h0001; endproperty
    property p_init; $rose(init_pin) |-> ##[1:3] (prog_count == `VEC_INIT); endproperty
    // with both synthesizers on, a free grant can be two instruction cycles away
    property p_wake; $fell(io_wake) |-> ##[1:33] (prog_count == `VEC_WAKE); endproperty
    // a pending wake may take the first free grant ahead of the interrupt
    property p_irq; irq_req |=> ##[0:64] (prog_count == {12'h001, irq_num}); endproperty
    property p_reg; s_ovl_wr |=> reg_rdata == $past(reg_wdata, 2); endproperty
    a_take_rd: assert property (p_take_rd) else $error("no rom access at fetch");
    a_onehot: assert property (p_onehot) else $error("rom selects not one-hot");
    a_high_ext: assert property (p_high_ext) else $error("high address not external");
    a_exc_int: assert property (p_exc_int) else $error("excitation not internal");
    a_fetch_res: assert property (p_fetch_res) else $error("fetch result late");
    a_fetch_pc: assert property (p_fetch_pc) else $error("pc not incremented");
    a_init: assert property (p_init) else $error("init vector missed");
    a_wake: assert property (p_wake) else $error("wake vector missed");
    a_irq: assert property (p_irq) else $error("irq vector missed");
    a_reg: assert property (p_reg) else $error("overlay readback wrong");
endmodule // rom_address_generation_asserts
bind rom_address_generation rom_address_generation_asserts u_chk (.*);
`default_nettype wire

// ===== test/ext_rom_model.sv
`default_nettype none
module ext_rom_model (
    input wire logic mclk, // clock
    input wire logic rom_rd, // access
    input wire logic rom_ext_sel, // external select
    input wire logic rom_int_sel, // internal select
    input wire logic [22:0] output_rom_address, // address
    output logic [7:0] rom_ext_data, // external byte
    output logic [7:0] rom_int_data // internal byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tog = 1'b0;
    always @(posedge mclk) tog <= ~tog;
    // unselected banks churn so a stale byte is never taken for data
    assign rom_ext_data = (rom_rd && rom_ext_sel) ?
        output_rom_address[7:0] ^ 8'hA5 : {8{tog}};
    assign rom_int_data = (rom_rd && rom_int_sel) ?
        output_rom_address[7:0] ^ 8'h5A : {8{~tog}};
endmodule // ext_rom_model
`default_nettype wire

// ===== test/testbench.sv
`include "rom_addr_map.vh"
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, sys_rst = 1, init_pin = 0, io_wake = 1, irq_req = 0, op_valid = 0, reg_wr = 0;
    logic [3:0] irq_line = 0;
    logic [1:0] synth_en = 0;
    logic [2:0] op_code = 0;
    logic [15:0] op_arg = 0, acc_value = 0, prog_count;
    logic [11:0] reg_addr = 0;
    logic [7:0] reg_wdata = 0, reg_rdata, rom_ext_data, rom_int_data, result_data, got_d;
    logic [22:0] output_rom_address, got_ad;
    logic rom_rd, rom_ext_sel, rom_int_sel, op_taken, result_valid, got_ext, got_int;
    logic [1:0] result_dest, got_dest;
    int checked = 0, n_fail = 0, n_tk;
    rom_address_generation #(.FETCH_DIV(16)) u_rom_address_generation (.*);
    ext_rom_model u_ext_rom_model (.*);
    initial forever #4 mclk = ~mclk;
    task automatic end_of_test;
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        `CHK("reg_rdata", e, reg_rdata)
    endtask
    task automatic op(input logic [2:0] c, input logic [15:0] arg, input logic [15:0] acc);
        int n;
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_arg <= arg;
        acc_value <= acc;
        n = 0;
        do @(negedge mclk); while (op_taken !== 1'b1 && ++n < 40);
        `CHK("op_taken", 1'b1, op_taken)
        got_ad = output_rom_address;
        got_ext = rom_ext_sel;
        got_int = rom_int_sel;
        @(posedge mclk);
        op_valid <= 1'b0;
        n = 0;
        if (c == `OP_JUMP || c == `OP_SETUP)
            repeat (16) @(negedge mclk);
        else
            do @(negedge mclk); while (result_valid !== 1'b1 && ++n < 40);
        got_d = result_data;
        got_dest = result_dest;
    endtask
    task automatic map(input logic [7:0] ps, ss, input logic ov, input logic [15:0] offs,
                       input logic [2:0] c);
        logic [22:0] e;
        logic x;
        e = (offs < 16'h8000) ? {7'h00, offs} + {3'h0, ps, 12'h000}
            : {8'h00, offs[14:0]} + {ss, 15'h0000};
        x = ov || (e > `INT_TOP);
        wr(`REG_PROG_SEG, ps);
        wr(`REG_SPEECH_SEG, ss);
        wr(`REG_OVERLAY, {7'h00, ov});
        op(c, 16'h0000, offs);
        `CHK("address", e, got_ad)
        `CHK("ext_sel", x, got_ext)
        `CHK("data", x ? e[7:0] ^ 8'hA5 : e[7:0] ^ 8'h5A, got_d)
        `CHK("dest", c == `OP_BYTE_ACC ? `DEST_A : `DEST_B, got_dest)
    endtask
    // any 64 clocks hold four slot-0 edges of four consecutive phases
    task automatic rate(input logic [1:0] se, input int exp_n);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= `OP_FETCH;
        synth_en <= se;
        n_tk = 0;
        @(negedge mclk);
        repeat (64) begin
            @(negedge mclk);
            if (op_taken === 1'b1) n_tk++;
        end
        `CHK("fetch_rate", exp_n, n_tk)
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(`REG_PROG_SEG, `RST_PROG_SEG);
        rd(`REG_SPEECH_SEG, `RST_SPEECH_SEG);
        rd(`REG_OVERLAY, `RST_OVERLAY);
        `CHK("pc", 16'h0000, prog_count)
        wr(12'hFEF, 8'h5A);
        rd(12'hFEF, 8'h00);
        $display("test registers done");
        map(8'h00, 8'h00, 1'b0, 16'h0FFF, `OP_BYTE_ACC);
        map(8'h00, 8'h00, 1'b1, 16'h0010, `OP_BYTE_B);
        map(8'h00, 8'h00, 1'b0, 16'h1000, `OP_BYTE_ACC);
        map(8'h03, 8'h00, 1'b0, 16'h7FFF, `OP_BYTE_B);
        map(8'h00, 8'hFF, 1'b0, 16'hFFFF, `OP_BYTE_ACC);
        map(8'h10, 8'h02, 1'b0, 16'h8000, `OP_BYTE_B);
        $display("test mapping done");
        op(`OP_JUMP, 16'h0200, 16'h0000);
        `CHK("pc", 16'h0200, prog_count)
        op(`OP_FETCH, 16'h0000, 16'h0000);
        `CHK("fetch_addr", 23'h010200, got_ad)
        `CHK("pc", 16'h0201, prog_count)
        `CHK("fetch_data", 8'hA5, got_d)
        `CHK("dest", `DEST_INSTR, got_dest)
        wr(`REG_PROG_SEG, 8'h00);
        op(`OP_SETUP, 16'h0020, 16'h0000);
        op(`OP_GET, 16'h0007, 16'h0000);
        `CHK("get8", 8'h20 ^ 8'h5A, got_d)
        op(`OP_GET, 16'h0003, 16'h0000);
        `CHK("get4", 8'h07, got_d)
        op(`OP_GET, 16'h0000, 16'h0000);
        `CHK("get1", 8'h01, got_d)
        op(`OP_EXC, 16'h1000, 16'h0000);
        `CHK("exc_int", 1'b1, got_int)
        `CHK("exc_addr", 23'h001000, got_ad)
        `CHK("exc_dest", `DEST_AUX, got_dest)
        op(`OP_PITCH, 16'h0040, 16'h0000);
        `CHK("pitch_addr", 23'h000040, got_ad)
        `CHK("pitch_dest", `DEST_AUX, got_dest)
        $display("test operations done");
        rate(2'h0, 4);
        rate(2'h1, 3);
        rate(2'h2, 3);
        rate(2'h3, 2);
        @(posedge mclk);
        op_valid <= 1'b0;
        synth_en <= 2'h0;
        $display("test rate done");
        repeat (20) @(posedge mclk);
        io_wake <= 1'b0;
        repeat (30) @(negedge mclk);
        `CHK("wake_pc", `VEC_WAKE, prog_count)
        @(posedge mclk);
        io_wake <= 1'b1;
        irq_req <= 1'b1;
        irq_line <= 4'h5;
        @(posedge mclk);
        irq_req <= 1'b0;
        repeat (30) @(negedge mclk);
        `CHK("irq_pc", 16'h0015, prog_count)
        wr(`REG_PROG_SEG, 8'h33);
        @(posedge mclk);
        init_pin <= 1'b1;
        repeat (4) @(posedge mclk);
        init_pin <= 1'b0;
        rd(`REG_PROG_SEG, 8'h00);
        `CHK("init_pc", `VEC_INIT, prog_count)
        $display("test vectors done");
        end_of_test;
    end
    initial begin
        #100us;
        n_fail++;
        end_of_test;
    end
endmodule // testbench
`default_nettype wire
